// ===== hdl/adc_cfg_pkg.sv
// Register map, field layout and reset values for the current ADC front
// end configuration block.
// Assumes a single 20 MHz system clock and a byte-wide register index.
package adc_cfg_pkg;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int CORE_CLK_HZ = 20_000_000;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] OFF_MCLK_A = 8'h05;
  localparam logic [7:0] OFF_MCLK_B = 8'h06;
  localparam logic [7:0] OFF_DECIM  = 8'h07;
  localparam logic [7:0] OFF_CAL1   = 8'h08;
  localparam logic [7:0] OFF_CAL0   = 8'h09;
  localparam logic [7:0] OFF_SELECT = 8'h0a;
  localparam logic [7:0] OFF_EXT    = 8'h0b;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LO16_LSB = 0;
  localparam int HI16_LSB = 16;
  localparam int RAW0_LSB = 0;
  localparam int RAW1_LSB = 8;
  localparam int UX_LSB   = 24;
  localparam int V_LSB    = 26;
  localparam int WY_LSB   = 28;
  // Output follows accumulator bit 30 so that f = inc * f_clk / 2^31
  localparam int ACC_TOP  = 30;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] MCLK_RST   = 32'h0000_0000;
  localparam logic [31:0] DECIM_RST  = 32'h0000_0000;
  // Unity gain with the default shift
  localparam logic [31:0] CAL_RST    = 32'h0100_0000;
  // UX=I0, V=I1, WY=I2, raw1 from modulator 1, raw0 from modulator 0
  localparam logic [31:0] SELECT_RST = 32'h2400_0100;
  localparam logic [31:0] EXT_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] SRC_MOD0 = 8'h00;
  localparam logic [7:0] SRC_MOD1 = 8'h01;
  localparam logic [7:0] SRC_EXT0 = 8'h02;
  localparam logic [7:0] SRC_EXT1 = 8'h03;
  localparam logic [1:0] PICK_I0  = 2'h0;
  localparam logic [1:0] PICK_I1  = 2'h1;
  localparam logic [1:0] PICK_I2  = 2'h2;

  localparam int GAIN_SHIFT_DFLT = 8;

endpackage : adc_cfg_pkg

// ===== hdl/current_adc_frontend_config.sv
// Current measurement front end configuration: modulator clocks, decimation
// settings, calibration, raw source selection and phase current routing.
// Assumes modulator samples come from logic on CORE_CLK; register port is
// driven synchronously by the serial interface logic.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Modulator clocks A, B from 32-bit increments
// - Decimation A bits 15:0, B 31:16
// - Channel 1 offset and signed gain correction
// - Channel 0 offset and signed gain correction
// - Raw source selectors, codes 0 to 3
// - I2 computed from measured currents, selectable
// - UX pick bits 25:24, reset I0
// - V pick bits 27:26, reset I1
// - WY pick bits 29:28, reset I2
// - Host current values, ch0 low, ch1 high
module current_adc_frontend_config #(
  parameter int GAIN_SHIFT = adc_cfg_pkg::GAIN_SHIFT_DFLT
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [15:0] MOD0_SAMPLE,
  input  wire logic [15:0] MOD1_SAMPLE,
  output logic [31:0]      REG_RDATA,
  output logic             MCLK_A,
  output logic             MCLK_B,
  output logic [15:0]      DECIM_RATE_A,
  output logic [15:0]      DECIM_RATE_B,
  output logic             PWM_SYNC_A,
  output logic             PWM_SYNC_B,
  output logic [15:0]      PHASE_UX_CURRENT,
  output logic [15:0]      PHASE_V_CURRENT,
  output logic [15:0]      PHASE_WY_CURRENT
);

  if (GAIN_SHIFT < 0 || GAIN_SHIFT > 15) begin : g_chk
    $error("GAIN_SHIFT must lie in 0..15");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) return 16'h7fff;
    if (v < -34'sd32768) return 16'h8000;
    return v[15:0];
  endfunction : sat16

  function automatic logic [15:0] calibrate(input logic [15:0] raw,
                                             input logic [31:0] cal);
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    diff = $signed({1'b0, raw}) - $signed({1'b0, cal[15:0]});
    prod = 34'(diff * $signed(cal[31:16]));
    return sat16(prod >>> GAIN_SHIFT);
  endfunction : calibrate

  function automatic logic [15:0] source(input logic [7:0] code,
                                          input logic [31:0] ext);
    case (code)
      adc_cfg_pkg::SRC_MOD0: return MOD0_SAMPLE;
      adc_cfg_pkg::SRC_MOD1: return MOD1_SAMPLE;
      adc_cfg_pkg::SRC_EXT0: return ext[15:0];
      adc_cfg_pkg::SRC_EXT1: return ext[31:16];
      default:               return 16'h0000;
    endcase
  endfunction : source

  function automatic logic [15:0] pick(input logic [1:0] code,
                                        input logic [15:0] i0,
                                        input logic [15:0] i1,
                                        input logic [15:0] i2);
    case (code)
      adc_cfg_pkg::PICK_I0: return i0;
      adc_cfg_pkg::PICK_I1: return i1;
      adc_cfg_pkg::PICK_I2: return i2;
      default:              return 16'h0000;
    endcase
  endfunction : pick

  function automatic logic [15:0] neg_sum(input logic [15:0] a,
                                           input logic [15:0] b);
    return sat16(-(34'($signed(a)) + 34'($signed(b))));
  endfunction : neg_sum

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] mclk_a_ff, mclk_b_ff, decim_ff, cal1_ff, cal0_ff;
  logic [31:0] select_ff, ext_ff, rdata_ff;
  logic [31:0] nxt_mclk_a, nxt_mclk_b, nxt_decim, nxt_cal1, nxt_cal0;
  logic [31:0] nxt_select, nxt_ext, nxt_rdata;
  logic        sync_a_ff, sync_b_ff;

  always_comb begin
    nxt_mclk_a = mclk_a_ff;
    nxt_mclk_b = mclk_b_ff;
    nxt_decim  = decim_ff;
    nxt_cal1   = cal1_ff;
    nxt_cal0   = cal0_ff;
    nxt_select = select_ff;
    nxt_ext    = ext_ff;
    if (REG_WR) begin
      case (REG_ADDR)
        adc_cfg_pkg::OFF_MCLK_A: nxt_mclk_a = REG_WDATA;
        adc_cfg_pkg::OFF_MCLK_B: nxt_mclk_b = REG_WDATA;
        adc_cfg_pkg::OFF_DECIM:  nxt_decim  = REG_WDATA;
        adc_cfg_pkg::OFF_CAL1:   nxt_cal1   = REG_WDATA;
        adc_cfg_pkg::OFF_CAL0:   nxt_cal0   = REG_WDATA;
        adc_cfg_pkg::OFF_SELECT: nxt_select = REG_WDATA;
        adc_cfg_pkg::OFF_EXT:    nxt_ext    = REG_WDATA;
        default: ;
      endcase
    end
    // Unmapped indices read as zero
    nxt_rdata = rdata_ff;
    if (REG_RD) begin
      case (REG_ADDR)
        adc_cfg_pkg::OFF_MCLK_A: nxt_rdata = mclk_a_ff;
        adc_cfg_pkg::OFF_MCLK_B: nxt_rdata = mclk_b_ff;
        adc_cfg_pkg::OFF_DECIM:  nxt_rdata = decim_ff;
        adc_cfg_pkg::OFF_CAL1:   nxt_rdata = cal1_ff;
        adc_cfg_pkg::OFF_CAL0:   nxt_rdata = cal0_ff;
        adc_cfg_pkg::OFF_SELECT: nxt_rdata = select_ff;
        adc_cfg_pkg::OFF_EXT:    nxt_rdata = ext_ff;
        default:                 nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      mclk_a_ff <= adc_cfg_pkg::MCLK_RST;
      mclk_b_ff <= adc_cfg_pkg::MCLK_RST;
      decim_ff  <= adc_cfg_pkg::DECIM_RST;
      cal1_ff   <= adc_cfg_pkg::CAL_RST;
      cal0_ff   <= adc_cfg_pkg::CAL_RST;
      select_ff <= adc_cfg_pkg::SELECT_RST;
      ext_ff    <= adc_cfg_pkg::EXT_RST;
      rdata_ff  <= 32'h0000_0000;
      sync_a_ff <= 1'b1;
      sync_b_ff <= 1'b1;
    end else begin
      mclk_a_ff <= nxt_mclk_a;
      mclk_b_ff <= nxt_mclk_b;
      decim_ff  <= nxt_decim;
      cal1_ff   <= nxt_cal1;
      cal0_ff   <= nxt_cal0;
      select_ff <= nxt_select;
      ext_ff    <= nxt_ext;
      rdata_ff  <= nxt_rdata;
      // Zero rate means decimate in step with the PWM period
      sync_a_ff <= (nxt_decim[15:0] == 16'h0000);
      sync_b_ff <= (nxt_decim[31:16] == 16'h0000);
    end
  end

  // ----------------------------------------------------------------------
  // Modulator clock generators
  // ----------------------------------------------------------------------
  logic [31:0] acc_a_ff, acc_b_ff, nxt_acc_a, nxt_acc_b;
  logic [31:0] low_a, low_b;
  logic        carry_a, carry_b, mclk_a_q_ff, mclk_b_q_ff;

  always_comb begin
    // Bit 30 flips on a carry into it or an increment bit 30, not both; toggling
    // there gives four times the rate of a toggle on the bit 31 carry
    low_a     = {2'b00, acc_a_ff[29:0]} + {2'b00, mclk_a_ff[29:0]};
    low_b     = {2'b00, acc_b_ff[29:0]} + {2'b00, mclk_b_ff[29:0]};
    carry_a   = low_a[adc_cfg_pkg::ACC_TOP]
                ^ mclk_a_ff[adc_cfg_pkg::ACC_TOP];
    carry_b   = low_b[adc_cfg_pkg::ACC_TOP]
                ^ mclk_b_ff[adc_cfg_pkg::ACC_TOP];
    nxt_acc_a = acc_a_ff + mclk_a_ff;
    nxt_acc_b = acc_b_ff + mclk_b_ff;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      acc_a_ff    <= 32'h0000_0000;
      acc_b_ff    <= 32'h0000_0000;
      mclk_a_q_ff <= 1'b0;
      mclk_b_q_ff <= 1'b0;
    end else begin
      acc_a_ff    <= nxt_acc_a;
      acc_b_ff    <= nxt_acc_b;
      mclk_a_q_ff <= mclk_a_q_ff ^ carry_a;
      mclk_b_q_ff <= mclk_b_q_ff ^ carry_b;
    end
  end

  // ----------------------------------------------------------------------
  // Current datapath: raw select, calibrate, route to phases
  // ----------------------------------------------------------------------
  logic [15:0] raw0_ff, raw1_ff, cur0_ff, cur1_ff, cur2_ff;
  logic [15:0] ux_ff, v_ff, wy_ff;
  logic [15:0] nxt_raw0, nxt_raw1, nxt_cur0, nxt_cur1, nxt_cur2;
  logic [15:0] nxt_ux, nxt_v, nxt_wy;

  always_comb begin
    nxt_raw0 = source(select_ff[adc_cfg_pkg::RAW0_LSB +: 8], ext_ff);
    nxt_raw1 = source(select_ff[adc_cfg_pkg::RAW1_LSB +: 8], ext_ff);
    nxt_cur0 = calibrate(raw0_ff, cal0_ff);
    nxt_cur1 = calibrate(raw1_ff, cal1_ff);
    // Balanced phases: third current is minus the sum of the other two
    nxt_cur2 = neg_sum(nxt_cur0, nxt_cur1);
    nxt_ux = pick(select_ff[adc_cfg_pkg::UX_LSB +: 2],
                  cur0_ff, cur1_ff, cur2_ff);
    nxt_v  = pick(select_ff[adc_cfg_pkg::V_LSB +: 2],
                  cur0_ff, cur1_ff, cur2_ff);
    nxt_wy = pick(select_ff[adc_cfg_pkg::WY_LSB +: 2],
                  cur0_ff, cur1_ff, cur2_ff);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      raw0_ff <= 16'h0000;
      raw1_ff <= 16'h0000;
      cur0_ff <= 16'h0000;
      cur1_ff <= 16'h0000;
      cur2_ff <= 16'h0000;
      ux_ff   <= 16'h0000;
      v_ff    <= 16'h0000;
      wy_ff   <= 16'h0000;
    end else begin
      raw0_ff <= nxt_raw0;
      raw1_ff <= nxt_raw1;
      cur0_ff <= nxt_cur0;
      cur1_ff <= nxt_cur1;
      cur2_ff <= nxt_cur2;
      ux_ff   <= nxt_ux;
      v_ff    <= nxt_v;
      wy_ff   <= nxt_wy;
    end
  end

  assign REG_RDATA        = rdata_ff;
  assign MCLK_A           = mclk_a_q_ff;
  assign MCLK_B           = mclk_b_q_ff;
  assign DECIM_RATE_A     = decim_ff[adc_cfg_pkg::LO16_LSB +: 16];
  assign DECIM_RATE_B     = decim_ff[adc_cfg_pkg::HI16_LSB +: 16];
  assign PWM_SYNC_A       = sync_a_ff;
  assign PWM_SYNC_B       = sync_b_ff;
  assign PHASE_UX_CURRENT = ux_ff;
  assign PHASE_V_CURRENT  = v_ff;
  assign PHASE_WY_CURRENT = wy_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  sequence s_cal0_write;
    REG_WR && REG_ADDR == adc_cfg_pkg::OFF_CAL0;
  endsequence
  sequence s_route_wy_i2;
    select_ff[adc_cfg_pkg::WY_LSB +: 2] == adc_cfg_pkg::PICK_I2;
  endsequence

  property p_mclk_toggle;
    carry_a |=> MCLK_A != $past(MCLK_A);
  endproperty
  a_mclk_toggle: assert property (p_mclk_toggle)
    else $error("modulator clock A missed a toggle");

  property p_mclk_hold;
    !carry_b |=> MCLK_B == $past(MCLK_B);
  endproperty
  a_mclk_hold: assert property (p_mclk_hold)
    else $error("modulator clock B toggled without carry");

  property p_decim_sync;
    REG_WR && REG_ADDR == adc_cfg_pkg::OFF_DECIM
      |=> PWM_SYNC_B == ($past(REG_WDATA[31:16]) == 16'h0000)
          && DECIM_RATE_A == $past(REG_WDATA[15:0]);
  endproperty
  a_decim_sync: assert property (p_decim_sync)
    else $error("decimation setting not applied");

  property p_cal0;
    s_cal0_write ##1 !REG_WR [*2]
      |-> cur0_ff == calibrate($past(raw0_ff), cal0_ff);
  endproperty
  a_cal0: assert property (p_cal0)
    else $error("channel 0 calibration wrong");

  property p_cal1;
    cur1_ff == calibrate($past(raw1_ff), $past(cal1_ff));
  endproperty
  a_cal1: assert property (p_cal1)
    else $error("channel 1 calibration wrong");

  property p_src_ext;
    select_ff[adc_cfg_pkg::RAW0_LSB +: 8] == adc_cfg_pkg::SRC_EXT1
      |=> raw0_ff == $past(ext_ff[31:16]);
  endproperty
  a_src_ext: assert property (p_src_ext)
    else $error("raw current 0 not from host channel 1");

  property p_sum;
    cur2_ff == neg_sum(cur0_ff, cur1_ff);
  endproperty
  a_sum: assert property (p_sum)
    else $error("third current does not balance the others");

  property p_route_wy;
    s_route_wy_i2 |=> PHASE_WY_CURRENT == $past(cur2_ff);
  endproperty
  a_route_wy: assert property (p_route_wy)
    else $error("phase WY not routed from third current");

  property p_reset_pick;
    $fell(RESET) |-> select_ff[29:24] == 6'h24;
  endproperty
  a_reset_pick: assert property (@(posedge CORE_CLK) p_reset_pick)
    else $error("phase picks wrong after reset");

endmodule : current_adc_frontend_config

`default_nettype wire

// ===== bench/modulator_model.sv
// Behavioural stand-in for the two current modulators feeding the block.
// Assumes the bench sets the wanted levels; samples follow one edge later.
`timescale 1ns/100ps
`default_nettype none
module modulator_model (
  input  wire logic        clk,
  input  wire logic [15:0] level0,
  input  wire logic [15:0] level1,
  output logic [15:0]      sample0,
  output logic [15:0]      sample1
);
  // --------------------------------------------------------------------
  // Sample registers
  // --------------------------------------------------------------------
  // Registered so the samples change only on the system clock edge
  always_ff @(posedge clk) begin
    sample0 <= level0;
    sample1 <= level1;
  end
endmodule : modulator_model
`default_nettype wire

// ===== bench/current_adc_frontend_config_tb.sv
// Self-checking bench for the current ADC front end configuration block.
// Assumes a 20 MHz clock and the register port timing of the hand-over.
`timescale 1ns/100ps
`default_nettype none
module current_adc_frontend_config_tb;
  logic        core_clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] level0;
  logic [15:0] level1;
  logic [15:0] mod0;
  logic [15:0] mod1;
  logic [31:0] rdata;
  logic        mclk_a;
  logic        mclk_b;
  logic [15:0] dec_a;
  logic [15:0] dec_b;
  logic        sync_a;
  logic        sync_b;
  logic [15:0] ux;
  logic [15:0] v;
  logic [15:0] wy;
  int          miscompares;
  int          checks_done;
  logic [15:0] srcv [4];
  logic [15:0] cur [4];

  current_adc_frontend_config dut_u (
    .CORE_CLK(core_clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .MOD0_SAMPLE(mod0), .MOD1_SAMPLE(mod1), .REG_RDATA(rdata),
    .MCLK_A(mclk_a), .MCLK_B(mclk_b), .DECIM_RATE_A(dec_a),
    .DECIM_RATE_B(dec_b), .PWM_SYNC_A(sync_a), .PWM_SYNC_B(sync_b),
    .PHASE_UX_CURRENT(ux), .PHASE_V_CURRENT(v), .PHASE_WY_CURRENT(wy)
  );
  modulator_model model_u (
    .clk(core_clk), .level0(level0), .level1(level1),
    .sample0(mod0), .sample1(mod1)
  );

  // --------------------------------------------------------------------
  // Clock and watchdog
  // --------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Fixed-latency waits only; this cuts any hang short
  initial begin
    #2_000_000;
    miscompares++;
    summarize();
  end

  // --------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    chk(rdata, exp);
  endtask : rd
  // Datapath is three edges deep plus the model's own edge
  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask : settle
  task automatic phases(input logic [15:0] a, b, c);
    settle();
    chk({16'h0, ux}, {16'h0, a});
    chk({16'h0, v}, {16'h0, b});
    chk({16'h0, wy}, {16'h0, c});
  endtask : phases
  task automatic toggles(input logic [31:0] na, input logic [31:0] nb);
    int   ca;
    int   cb;
    logic pa;
    logic pb;
    ca = 0;
    cb = 0;
    pa = mclk_a;
    pb = mclk_b;
    repeat (16) begin
      @(negedge core_clk);
      if (mclk_a !== pa) ca++;
      if (mclk_b !== pb) cb++;
      pa = mclk_a;
      pb = mclk_b;
    end
    chk(ca, na);
    chk(cb, nb);
  endtask : toggles
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    reset = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; level0 = 16'h0100; level1 = 16'h0080;
    miscompares = 0; checks_done = 0;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    rd(8'h05, 32'h0);
    rd(8'h06, 32'h0);
    rd(8'h07, 32'h0);
    rd(8'h08, 32'h0100_0000);
    rd(8'h09, 32'h0100_0000);
    rd(8'h0a, 32'h2400_0100);
    rd(8'h0b, 32'h0);
    chk({sync_a, sync_b}, 2'h3);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    $display("reset values done");
    wr(8'h07, 32'h0000_0010);
    chk({sync_a, sync_b, dec_a, dec_b}, {2'h1, 16'h0010, 16'h0});
    wr(8'h07, 32'h1234_0000);
    chk({sync_a, sync_b, dec_a, dec_b}, {2'h2, 16'h0, 16'h1234});
    rd(8'h07, 32'h1234_0000);
    $display("decimation done");
    toggles(0, 0);
    wr(8'h05, 32'h4000_0000);
    wr(8'h06, 32'h2000_0000);
    toggles(16, 8);
    rd(8'h05, 32'h4000_0000);
    rd(8'h06, 32'h2000_0000);
    $display("modulator clocks done");
    phases(16'h0100, 16'h0080, 16'hfe80);
    cur[0] = 16'h0100; cur[1] = 16'h0080; cur[2] = 16'hfe80; cur[3] = 16'h0;
    for (int p = 0; p < 3; p++) begin
      wr(8'h0a, 32'h0000_0100 | (p << 24) | (((p + 1) % 3) << 26)
                 | (((p + 2) % 3) << 28));
      phases(cur[p], cur[(p + 1) % 3],
             cur[(p + 2) % 3]);
    end
    wr(8'h0a, 32'h3000_0100);
    phases(16'h0100, 16'h0100, 16'h0);
    $display("phase routing done");
    wr(8'h0b, 32'h0300_0200);
    rd(8'h0b, 32'h0300_0200);
    srcv[0] = 16'h0100; srcv[1] = 16'h0080;
    srcv[2] = 16'h0200; srcv[3] = 16'h0300;
    for (int k = 0; k < 4; k++) begin
      wr(8'h0a, 32'h2400_0000 | k | ((3 - k) << 8));
      phases(srcv[k], srcv[3 - k],
             16'h0 - srcv[k] - srcv[3 - k]);
    end
    wr(8'h0a, 32'h2400_0100);
    $display("raw sources done");
    wr(8'h09, 32'h0200_0010);
    wr(8'h08, 32'hff00_0000);
    rd(8'h09, 32'h0200_0010);
    rd(8'h08, 32'hff00_0000);
    phases(16'h01e0, 16'hff80, 16'hfea0);
    $display("calibration done");
    summarize();
  end
endmodule : current_adc_frontend_config_tb
`default_nettype wire
